// ---- rtl/rpm_pin_select_maps.sv ----
// remappable pin select maps: input and output routing with registers
//
// Functional notes
// - bits 5-0 pick the pin for spi2 slave select; reset to all ones.
// - bits 13-8 pick the pin feeding uart4 clear-to-send.
// - bits 5-0 of that register pick the pin feeding uart4 receive.
// - bits 13-8 pick the pin used as spi3 clock input.
// - bits 5-0 of that register pick the pin used as spi3 data.
// - bits 5-0 pick the spi3 slave select pin; upper ten bits read zero.
// - output field value n, n nonzero, puts function n on the pin; zero drives nothing; resets to zero.
// - two output fields per register, even pin low, odd pin high.
// - small package: pin 5 output field absent, reads zero.
// - bits 15-14 and 7-6 with no field always read zero.
// - single low-field registers read zero in bits 15-6.
`timescale 1ns/1ps
module rpm_pin_select_maps
  import rpm_pkg::*;
#(
  parameter bit SMALL_PACKAGE = 1'b0
)
(
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // register port
  input wire rpm_pkg::rpm_addr_type REG_ADDR,
  input wire rpm_pkg::rpm_data_type REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output rpm_pkg::rpm_data_type REG_RDATA,
  // remappable pins and peripheral functions
  input wire logic [rpm_pkg::NUM_SRC-1:0] REMAPPABLE_IO_PIN_IN,
  input wire logic [rpm_pkg::NUM_SRC-1:0] PERIPH_FUNC_OUT,
  // peripheral inputs
  output logic SPI2_SLAVE_SELECT_IN,
  output logic UART4_CLEAR_TO_SEND_IN,
  output logic UART4_RECEIVE_IN,
  output logic SPI3_CLOCK_IN,
  output logic SPI3_DATA_IN,
  output logic SPI3_SLAVE_SELECT_IN,
  // remappable pin outputs
  output logic [rpm_pkg::NUM_OUT_PINS-1:0] REMAPPABLE_IO_PIN_OUT,
  output logic [rpm_pkg::NUM_OUT_PINS-1:0] REMAPPABLE_IO_PIN_OE
);
  import rpm_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // declarations

  rpm_sel_type in_sel_reg [NUM_IN_SEL];
  rpm_sel_type out_sel_reg [NUM_OUT_PINS];
  rpm_data_type rdata_reg;
  rpm_data_type rdata_next;
  logic [NUM_IN_SEL-1:0] in_route_reg;
  logic [NUM_IN_SEL-1:0] in_route_next;
  logic [NUM_OUT_PINS-1:0] pin_out_reg;
  logic [NUM_OUT_PINS-1:0] pin_out_next;
  logic [NUM_OUT_PINS-1:0] pin_oe_reg;
  logic [NUM_OUT_PINS-1:0] pin_oe_next;

  // high field in 13-8, low field in 5-0, gaps read zero
  function automatic rpm_data_type pack_pair(input rpm_sel_type hi,
                                             input rpm_sel_type lo);
    pack_pair = {2'b00, hi, 2'b00, lo};
  endfunction

  // true when the address hits output register k
  function automatic logic out_hit(input rpm_addr_type addr, input int k);
    out_hit = (addr == ADDR_OUT_MAP_BASE + ADDR_W'(k));
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // input-select fields

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < NUM_IN_SEL; i++) begin
        in_sel_reg[i] <= IN_SEL_RESET;
      end
    end else if (REG_WR) begin
      // bits outside the fields are simply dropped
      case (REG_ADDR)
        ADDR_SPI2_SS_MAP: begin
          in_sel_reg[IDX_SPI2_SS] <= REG_WDATA[LO_LSB +: SEL_W];
        end
        ADDR_UART4_MAP: begin
          in_sel_reg[IDX_UART4_CTS] <= REG_WDATA[HI_LSB +: SEL_W];
          in_sel_reg[IDX_UART4_RX] <= REG_WDATA[LO_LSB +: SEL_W];
        end
        ADDR_SPI3_CD_MAP: begin
          in_sel_reg[IDX_SPI3_CLK] <= REG_WDATA[HI_LSB +: SEL_W];
          in_sel_reg[IDX_SPI3_DATA] <= REG_WDATA[LO_LSB +: SEL_W];
        end
        ADDR_SPI3_SS_MAP: begin
          in_sel_reg[IDX_SPI3_SS] <= REG_WDATA[LO_LSB +: SEL_W];
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output-select fields, two per register

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int p = 0; p < NUM_OUT_PINS; p++) begin
        out_sel_reg[p] <= OUT_SEL_RESET;
      end
    end else if (REG_WR) begin
      for (int k = 0; k < NUM_OUT_REGS; k++) begin
        if (out_hit(REG_ADDR, k)) begin
          out_sel_reg[2*k] <= REG_WDATA[LO_LSB +: SEL_W];
          // absent field keeps its reset value
          if (!(SMALL_PACKAGE && (2*k+1 == ABSENT_PIN))) begin
            out_sel_reg[2*k+1] <= REG_WDATA[HI_LSB +: SEL_W];
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read port: data stand only in the cycle after the strobe

  always_comb begin
    rdata_next = RDATA_RESET;
    case (REG_ADDR)
      ADDR_SPI2_SS_MAP: begin
        rdata_next = pack_pair(FUNC_NONE, in_sel_reg[IDX_SPI2_SS]);
      end
      ADDR_UART4_MAP: begin
        rdata_next = pack_pair(in_sel_reg[IDX_UART4_CTS],
                               in_sel_reg[IDX_UART4_RX]);
      end
      ADDR_SPI3_CD_MAP: begin
        rdata_next = pack_pair(in_sel_reg[IDX_SPI3_CLK],
                               in_sel_reg[IDX_SPI3_DATA]);
      end
      ADDR_SPI3_SS_MAP: begin
        rdata_next = pack_pair(FUNC_NONE, in_sel_reg[IDX_SPI3_SS]);
      end
      default: begin
        for (int k = 0; k < NUM_OUT_REGS; k++) begin
          if (out_hit(REG_ADDR, k)) begin
            rdata_next = pack_pair(out_sel_reg[2*k+1], out_sel_reg[2*k]);
          end
        end
      end
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_reg <= RDATA_RESET;
    end else if (REG_RD) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= RDATA_RESET;
    end
  end

  assign REG_RDATA = rdata_reg;

  ////////////////////////////////////////////////////////////////////////
  // routing: pins to peripheral inputs, functions to pins

  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN_SEL; gi++) begin : g_in
      rpm_bit_select u_in_sel (
        .src(REMAPPABLE_IO_PIN_IN),
        .sel(in_sel_reg[gi]),
        .picked(in_route_next[gi])
      );
    end
    for (gi = 0; gi < NUM_OUT_PINS; gi++) begin : g_out
      rpm_pin_driver u_pin_drv (
        .func(PERIPH_FUNC_OUT),
        .sel(out_sel_reg[gi]),
        .level(pin_out_next[gi]),
        .drive(pin_oe_next[gi])
      );
    end
  endgenerate

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      in_route_reg <= '0;
    end else begin
      in_route_reg <= in_route_next;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pin_out_reg <= '0;
      pin_oe_reg <= '0;
    end else begin
      pin_out_reg <= pin_out_next;
      pin_oe_reg <= pin_oe_next;
    end
  end

  assign SPI2_SLAVE_SELECT_IN = in_route_reg[IDX_SPI2_SS];
  assign UART4_CLEAR_TO_SEND_IN = in_route_reg[IDX_UART4_CTS];
  assign UART4_RECEIVE_IN = in_route_reg[IDX_UART4_RX];
  assign SPI3_CLOCK_IN = in_route_reg[IDX_SPI3_CLK];
  assign SPI3_DATA_IN = in_route_reg[IDX_SPI3_DATA];
  assign SPI3_SLAVE_SELECT_IN = in_route_reg[IDX_SPI3_SS];
  assign REMAPPABLE_IO_PIN_OUT = pin_out_reg;
  assign REMAPPABLE_IO_PIN_OE = pin_oe_reg;

  ////////////////////////////////////////////////////////////////////////
  // assertions

  spi2_ss_write_a: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    REG_WR && REG_ADDR == ADDR_SPI2_SS_MAP |=>
      in_sel_reg[IDX_SPI2_SS] == $past(REG_WDATA[5:0]))
    else $error("spi2 slave select field not written");

  uart4_cts_route_a: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    REG_WR && REG_ADDR == ADDR_UART4_MAP ##1 !REG_WR |=>
      in_sel_reg[IDX_UART4_CTS] == $past(REG_WDATA[13:8], 2)
      && UART4_CLEAR_TO_SEND_IN ==
        $past(REMAPPABLE_IO_PIN_IN[in_sel_reg[IDX_UART4_CTS]]))
    else $error("uart4 cts not routed from selected pin");

  spi2_ss_route_a: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    1'b1 |=> SPI2_SLAVE_SELECT_IN ==
      $past(REMAPPABLE_IO_PIN_IN[in_sel_reg[IDX_SPI2_SS]]))
    else $error("spi2 slave select not routed from selected pin");

  uart4_rx_route_a: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    1'b1 |=> UART4_RECEIVE_IN ==
      $past(REMAPPABLE_IO_PIN_IN[in_sel_reg[IDX_UART4_RX]]))
    else $error("uart4 receive not routed from selected pin");

  uart4_rx_write_a: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    REG_WR && REG_ADDR == ADDR_UART4_MAP |=>
      in_sel_reg[IDX_UART4_RX] == $past(REG_WDATA[5:0]))
    else $error("uart4 receive field not written");

  spi3_clock_field_a: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    REG_WR && REG_ADDR == ADDR_SPI3_CD_MAP |=>
      in_sel_reg[IDX_SPI3_CLK] == $past(REG_WDATA[13:8]))
    else $error("spi3 clock field not written");

  spi3_data_route_a: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    1'b1 |=> SPI3_DATA_IN ==
      $past(REMAPPABLE_IO_PIN_IN[in_sel_reg[IDX_SPI3_DATA]]))
    else $error("spi3 data not routed from selected pin");

  spi3_ss_read_a: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    REG_RD && REG_ADDR == ADDR_SPI3_SS_MAP |=>
      REG_RDATA == {10'h000, $past(in_sel_reg[IDX_SPI3_SS])})
    else $error("spi3 slave select read wrong");

  pin_function_route_a: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    1'b1 |=> REMAPPABLE_IO_PIN_OE[0] == ($past(out_sel_reg[0]) != 6'h00)
      && REMAPPABLE_IO_PIN_OUT[0] == ($past(out_sel_reg[0]) != 6'h00
      && $past(PERIPH_FUNC_OUT[out_sel_reg[0]])))
    else $error("pin 0 not driven by selected function");

  out_pair_pack_a: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    REG_WR && REG_ADDR == 4'h7 |=>
      out_sel_reg[6] == $past(REG_WDATA[5:0])
      && out_sel_reg[7] == $past(REG_WDATA[13:8]))
    else $error("output pair fields misplaced");

  absent_pin_zero_a: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    SMALL_PACKAGE && REG_RD && REG_ADDR == 4'h6 |=> REG_RDATA[13:8] == 6'h00)
    else $error("absent pin 5 field reads nonzero");

  absent_pin_idle_a: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    SMALL_PACKAGE |-> out_sel_reg[ABSENT_PIN] == OUT_SEL_RESET
      && !REMAPPABLE_IO_PIN_OE[ABSENT_PIN])
    else $error("absent pin 5 field set or pin driven");

  gap_bits_zero_a: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    REG_RD && REG_ADDR != ADDR_SPI2_SS_MAP |=>
      REG_RDATA[15:14] == 2'b00 && REG_RDATA[7:6] == 2'b00)
    else $error("unimplemented gap bits read nonzero");

  low_only_read_a: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    REG_RD && REG_ADDR == ADDR_SPI2_SS_MAP |=> REG_RDATA[15:6] == 10'h000)
    else $error("upper bits of single-field register nonzero");

  foreign_write_kept_a: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    REG_WR && REG_ADDR == ADDR_SPI3_SS_MAP |=>
      $stable(in_sel_reg[IDX_SPI2_SS]) && $stable(in_sel_reg[IDX_UART4_CTS])
      && $stable(in_sel_reg[IDX_SPI3_CLK]) && $stable(out_sel_reg[1]))
    else $error("write disturbed another select field");

endmodule

// ---- common/rpm_pkg.sv ----
// constants and types shared by the remappable pin select maps
package rpm_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int SEL_W = 6;
  localparam int NUM_SRC = 64;
  localparam int NUM_IN_SEL = 6;
  localparam int NUM_OUT_PINS = 10;
  localparam int NUM_OUT_REGS = 5;

  typedef logic [SEL_W-1:0] rpm_sel_type;
  typedef logic [ADDR_W-1:0] rpm_addr_type;
  typedef logic [DATA_W-1:0] rpm_data_type;

  // register addresses on the plain register port
  localparam rpm_addr_type ADDR_SPI2_SS_MAP = 4'h0;
  localparam rpm_addr_type ADDR_UART4_MAP = 4'h1;
  localparam rpm_addr_type ADDR_SPI3_CD_MAP = 4'h2;
  localparam rpm_addr_type ADDR_SPI3_SS_MAP = 4'h3;
  localparam rpm_addr_type ADDR_OUT_MAP_BASE = 4'h4;

  // field positions inside a 16-bit register
  localparam int LO_LSB = 0;
  localparam int HI_LSB = 8;

  // values after power-on reset
  localparam rpm_sel_type IN_SEL_RESET = 6'h3F;
  localparam rpm_sel_type OUT_SEL_RESET = 6'h00;
  localparam rpm_data_type RDATA_RESET = 16'h0000;

  // function number that drives nothing
  localparam rpm_sel_type FUNC_NONE = 6'h00;

  // output pin whose field is absent in the small package
  localparam int ABSENT_PIN = 5;

  // slots of the input-select array
  localparam int IDX_SPI2_SS = 0;
  localparam int IDX_UART4_CTS = 1;
  localparam int IDX_UART4_RX = 2;
  localparam int IDX_SPI3_CLK = 3;
  localparam int IDX_SPI3_DATA = 4;
  localparam int IDX_SPI3_SS = 5;

endpackage

// ---- rtl/rpm_bit_select.sv ----
// picks one source line of a 64-line bus by a six-bit index
`timescale 1ns/1ps
module rpm_bit_select
  import rpm_pkg::*;
(
  // source lines
  input wire logic [NUM_SRC-1:0] src,
  // index
  input wire rpm_pkg::rpm_sel_type sel,
  // picked line
  output logic picked
);
  assign picked = src[sel];
endmodule

// ---- rtl/rpm_pin_driver.sv ----
// turns an output-select field into the pin level and its drive enable
`timescale 1ns/1ps
module rpm_pin_driver
  import rpm_pkg::*;
(
  // peripheral output functions
  input wire logic [NUM_SRC-1:0] func,
  // function number for this pin
  input wire rpm_pkg::rpm_sel_type sel,
  // pin level and enable
  output logic level,
  output logic drive
);
  // function number zero means the pin is left to its port logic
  assign drive = (sel != FUNC_NONE);
  assign level = drive ? func[sel] : 1'b0;
endmodule

// ---- test/rpm_far_side.sv ----
// far-side model: package pads and peripheral output functions
`timescale 1ns/1ps
module rpm_far_side
  import rpm_pkg::*;
(
  // levels presented by the board and by the peripherals
  input wire logic [rpm_pkg::NUM_SRC-1:0] pin_lvl,
  input wire logic [rpm_pkg::NUM_SRC-1:0] func_lvl,
  // pad drive from the block
  input wire logic [rpm_pkg::NUM_OUT_PINS-1:0] pin_out,
  input wire logic [rpm_pkg::NUM_OUT_PINS-1:0] pin_oe,
  // resolved pads and function lines
  output logic [rpm_pkg::NUM_SRC-1:0] pin_in,
  output logic [rpm_pkg::NUM_SRC-1:0] func_out
);
  always_comb begin
    pin_in = pin_lvl;
    for (int p = 0; p < NUM_OUT_PINS; p++) begin
      if (pin_oe[p]) begin
        pin_in[p] = pin_out[p];
      end
    end
    func_out = func_lvl;
    // function 0 has no source: keep it moving so it cannot pass by luck
    func_out[0] = ~func_lvl[1];
  end
endmodule

// ---- test/testbench.sv ----
// self-checking bench for the remappable pin select maps
`timescale 1ns/1ps
module testbench;
  import rpm_pkg::*;
  `define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin \
    miscompares++; $display("ERROR t=%0t got=%h exp=%h", $time, a, e); \
    end end
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  rpm_addr_type addr = '0;
  rpm_data_type wdata = '0;
  rpm_data_type rdata, rdata_s;
  logic [63:0] pin_lvl = '0;
  logic [63:0] func_lvl = '0;
  logic [63:0] pin_in, func_out;
  logic [5:0] per_in;
  logic [9:0] pin_out, pin_oe, out_s, oe_s;
  rpm_sel_type f [10];
  int miscompares = 0;
  int cmp_count = 0;

  always #2.5 clk = ~clk;

  rpm_pin_select_maps #(.SMALL_PACKAGE(1'b0)) u_rpm_pin_select_maps (
    .REF_CLK(clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
    .REMAPPABLE_IO_PIN_IN(pin_in), .PERIPH_FUNC_OUT(func_out),
    .SPI2_SLAVE_SELECT_IN(per_in[0]), .UART4_CLEAR_TO_SEND_IN(per_in[1]),
    .UART4_RECEIVE_IN(per_in[2]), .SPI3_CLOCK_IN(per_in[3]),
    .SPI3_DATA_IN(per_in[4]), .SPI3_SLAVE_SELECT_IN(per_in[5]),
    .REMAPPABLE_IO_PIN_OUT(pin_out), .REMAPPABLE_IO_PIN_OE(pin_oe));

  rpm_pin_select_maps #(.SMALL_PACKAGE(1'b1)) u_rpm_pin_select_maps_small (
    .REF_CLK(clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata_s),
    .REMAPPABLE_IO_PIN_IN(pin_in), .PERIPH_FUNC_OUT(func_out),
    .SPI2_SLAVE_SELECT_IN(), .UART4_CLEAR_TO_SEND_IN(),
    .UART4_RECEIVE_IN(), .SPI3_CLOCK_IN(), .SPI3_DATA_IN(),
    .SPI3_SLAVE_SELECT_IN(), .REMAPPABLE_IO_PIN_OUT(out_s),
    .REMAPPABLE_IO_PIN_OE(oe_s));

  rpm_far_side u_rpm_far_side (.pin_lvl(pin_lvl), .func_lvl(func_lvl),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in),
    .func_out(func_out));

  ////////////////////////////////////////////////////////////////////////
  // expected read value after writing d to address a
  function automatic rpm_data_type fmask(int a, rpm_data_type d, bit sm);
    case (a)
      0, 3: return d & 16'h003F;
      1, 2, 4, 5, 7, 8: return d & 16'h3F3F;
      6: return sm ? (d & 16'h003F) : (d & 16'h3F3F);
      default: return 16'h0000;
    endcase
  endfunction

  task automatic wr_reg(input int a, input rpm_data_type d);
    @(posedge clk);
    addr <= 4'(a);
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input int a, input rpm_data_type e, es);
    @(posedge clk);
    addr <= 4'(a);
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, e)
    `CHK(rdata_s, es)
  endtask

  task automatic do_reset;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rpm_data_type e;
    pin_lvl <= 64'h8000_0000_0000_0000;
    repeat (3) @(posedge clk);
    #1;
    `CHK(per_in, 6'h3F)
    `CHK(pin_oe, 10'h000)
    for (int a = 0; a < 10; a++) begin
      e = (a < 4) ? fmask(a, 16'hFFFF, 1'b0) : 16'h0000;
      rd_chk(a, e, e);
    end
  endtask

  task automatic t_regs;
    rpm_data_type d;
    for (int i = 0; i < 2; i++) begin
      d = i ? 16'hD5EA : 16'hFFFF;
      for (int a = 0; a < 10; a++) begin
        wr_reg(a, d);
        rd_chk(a, fmask(a, d, 1'b0), fmask(a, d, 1'b1));
      end
    end
  endtask

  task automatic t_in_route;
    logic [63:0] hot;
    for (int a = 4; a < 9; a++) wr_reg(a, 16'h0000);
    wr_reg(0, 16'h000C);
    wr_reg(1, 16'h1421);
    wr_reg(2, 16'h2F3A);
    wr_reg(3, 16'h0003);
    hot = '0;
    hot[12] = 1'b1;
    hot[20] = 1'b1;
    hot[33] = 1'b1;
    hot[47] = 1'b1;
    hot[58] = 1'b1;
    hot[3] = 1'b1;
    for (int v = 0; v < 2; v++) begin
      @(posedge clk);
      pin_lvl <= v ? hot : ~hot;
      repeat (2) @(posedge clk);
      #1;
      `CHK(per_in, v ? 6'h3F : 6'h00)
    end
  endtask

  task automatic t_out_route;
    logic [9:0] eo, ee;
    for (int p = 0; p < 10; p++) f[p] = (p == 9) ? 6'h00 : 6'(p * 6 + 1);
    for (int k = 0; k < 5; k++) begin
      wr_reg(4 + k, {2'b00, f[2*k+1], 2'b00, f[2*k]});
    end
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      func_lvl <= i ? ~64'hA5C3_0F96_3C5A_E187 : 64'hA5C3_0F96_3C5A_E187;
      repeat (3) @(posedge clk);
      #1;
      for (int p = 0; p < 10; p++) begin
        ee[p] = (f[p] != 6'h00);
        eo[p] = ee[p] ? func_lvl[f[p]] : 1'b0;
      end
      `CHK(pin_out, eo)
      `CHK(pin_oe, ee)
      `CHK(out_s, eo & 10'h3DF)
      `CHK(oe_s, ee & 10'h3DF)
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("miscompares=%0d cmp_count=%0d", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    test_done();
  end

  initial begin
    do_reset();
    t_reset();
    t_regs();
    t_in_route();
    t_out_route();
    do_reset();
    t_reset();
    test_done();
  end
endmodule
